// >>> rtl/accel_cfg.svh
/*
 * Constants of the checksum / CRC accelerator: register indices,
 * configuration field positions, seeds, polynomials and masks.
 * Assumes it is included by the package and by the design modules.
 */
`ifndef ACCEL_CFG_SVH
`define ACCEL_CFG_SVH

// avalon-mm geometry
`define AV_ADDR_W       18
`define AV_DATA_W       32

// register indices, byte address is four times the index
`define IDX_CONFIG      16'ha078
`define IDX_DATA0       16'ha07c
`define IDX_DATA1       16'ha07d
`define IDX_DATA2       16'ha07e
`define IDX_DATA3       16'ha07f

// configuration register layout
`define CFG_WIDTH_HI    7
`define CFG_WIDTH_LO    6
`define CFG_REVERSE     5
`define CFG_CARRY       4
`define CFG_SEED        3
`define CFG_BUSY        0
`define CFG_RESET       8'h00
`define BYTE_RESET      8'h00

// seeds and polynomials
`define SEED_CKS        32'h0000_0000
`define SEED_CRC16      32'h0000_ffff
`define SEED_CRC32      32'hffff_ffff
`define POLY16_A        32'h0000_8005
`define POLY16_B        32'h0000_1021
`define POLY32          32'h04c1_1db7

// masks
`define ALL_ONES        32'hffff_ffff
`define MASK_8          32'h0000_00ff
`define MASK_16         32'h0000_ffff

`endif

// >>> rtl/accel_pkg.sv
/*
 * Types and small helper functions shared by the accelerator modules.
 * Assumes accel_cfg.svh is on the include path.
 */
`include "accel_cfg.svh"

package accel_pkg;

	typedef enum logic [2:0] {
		ALG_OFF    = 3'b000,
		ALG_CKS8   = 3'b001,
		ALG_CKS32  = 3'b010,
		ALG_CRC16A = 3'b011,
		ALG_CRC16B = 3'b100,
		ALG_CRC32  = 3'b101,
		ALG_RSVD   = 3'b110,
		ALG_CLEAR  = 3'b111
	} alg_e;

	typedef enum logic [1:0] {
		W8  = 2'b00,
		W16 = 2'b01,
		W24 = 2'b10,
		W32 = 2'b11
	} width_e;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} phase_e;

	typedef struct packed {
		width_e input_width_sel;
		logic   reverse;
		logic   carry_discard;
		logic   seed;
		alg_e   algorithm_select;
	} cfg_s;

	typedef struct packed {
		logic [31:0] acc;
		logic        carry;
	} engine_s;

	function automatic logic [31:0] width_mask(input width_e w);
		return `ALL_ONES >> {~w, 3'b000};
	endfunction

	function automatic logic [31:0] alg_mask(input alg_e a);
		case (a)
			ALG_CKS8:               return `MASK_8;
			ALG_CRC16A, ALG_CRC16B: return `MASK_16;
			default:                return `ALL_ONES;
		endcase
	endfunction

	function automatic logic [31:0] seed_default(input alg_e a);
		case (a)
			ALG_CRC16A, ALG_CRC16B: return `SEED_CRC16;
			ALG_CRC32:              return `SEED_CRC32;
			default:                return `SEED_CKS;
		endcase
	endfunction

	function automatic logic is_active(input alg_e a);
		return a inside {ALG_CKS8, ALG_CKS32, ALG_CRC16A, ALG_CRC16B,
			ALG_CRC32};
	endfunction

endpackage

// >>> rtl/checksum_crc_accelerator.sv
/*
 * Checksum / CRC accelerator with its register file on an Avalon-MM
 * slave with waitrequest.
 * Assumes one clock sys_clk, synchronous active-high reset and a master
 * that holds each request until it sees waitrequest low.
 */
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "accel_cfg.svh"

////////////////////////////////////////////////////////////////////////

module checksum_crc_accelerator
	import accel_pkg::*;
(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	// avalon-mm slave
	input  wire logic [`AV_ADDR_W-1:0] address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [`AV_DATA_W-1:0] writedata,
	input  wire logic [3:0]            byteenable,
	output logic      [`AV_DATA_W-1:0] readdata,
	output logic                       waitrequest
);

	cfg_s        cfg;
	cfg_s        wr_cfg;
	engine_s     eng;
	engine_s     next_eng;
	phase_e      phase;
	logic        busy;
	logic        first_step;
	logic [1:0]  steps_left;
	logic [23:0] entry_hi;
	logic [31:0] entry_word;
	logic [31:0] seed_word;
	logic [31:0] mirrored;
	logic [31:0] work;
	logic [7:0]  cur_byte;
	logic [31:0] read_value;
	logic        hit_cfg;
	logic        hit_d0;
	logic        hit_d1;
	logic        hit_d2;
	logic        hit_d3;
	logic        hold;
	logic        take;
	logic        fire_wr;
	logic        cfg_wr;
	logic        clear_cmd;
	logic        seed_load;
	logic        start;

	function automatic logic hits(input logic [`AV_ADDR_W-1:0] a,
			input logic [15:0] idx);
		return a[`AV_ADDR_W-1:2] == idx;
	endfunction

	////////////////////////////////////////////////////////////////////
	// decode

	assign hit_cfg = hits(address, `IDX_CONFIG);
	assign hit_d0  = hits(address, `IDX_DATA0);
	assign hit_d1  = hits(address, `IDX_DATA1);
	assign hit_d2  = hits(address, `IDX_DATA2);
	assign hit_d3  = hits(address, `IDX_DATA3);

	// only the low lane carries a register, other lanes are ignored
	assign fire_wr   = write & ~waitrequest & byteenable[0];
	assign wr_cfg    = cfg_s'(writedata[7:0]);
	assign cfg_wr    = fire_wr & hit_cfg;
	assign clear_cmd = cfg_wr & (wr_cfg.algorithm_select == ALG_CLEAR);
	assign entry_word = {entry_hi, writedata[7:0]};
	assign seed_load = fire_wr & hit_d0 & cfg.seed;
	assign start     = fire_wr & hit_d0 & ~cfg.seed &
		is_active(cfg.algorithm_select);

	// seed bypasses the mirror, so reverse never touches it
	assign seed_word = entry_word & width_mask(cfg.input_width_sel) &
		alg_mask(cfg.algorithm_select);

	assign busy     = (phase == PH_RUN);
	assign cur_byte = work[{steps_left, 3'b000} +: 8];

	////////////////////////////////////////////////////////////////////
	// avalon-mm slave

	// a config read may pass while busy so software can see the flag
	assign hold = busy & ~(read & hit_cfg);
	assign take = (read | write) & ~hold;

	always_comb begin
		read_value = {`AV_DATA_W{1'b0}};
		if (hit_cfg) begin
			read_value[7:0] = {cfg.input_width_sel, cfg.reverse,
				cfg.carry_discard, cfg.seed, 2'b00, busy};
		end else if (hit_d0) begin
			read_value[7:0] = eng.acc[7:0];
		end else if (hit_d1) begin
			read_value[7:0] = eng.acc[15:8];
		end else if (hit_d2) begin
			read_value[7:0] = eng.acc[23:16];
		end else if (hit_d3) begin
			read_value[7:0] = eng.acc[31:24];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			waitrequest <= 1'b1;
			readdata    <= {`AV_DATA_W{1'b0}};
		end else if (!waitrequest) begin
			waitrequest <= 1'b1;
		end else if (take) begin
			waitrequest <= 1'b0;
			if (read) begin
				readdata <= read_value;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration and entry bytes

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg <= cfg_s'(`CFG_RESET);
		end else if (clear_cmd) begin
			// the reset command keeps the algorithm chosen before it
			cfg <= {wr_cfg[7:3], cfg.algorithm_select};
		end else if (cfg_wr) begin
			cfg <= wr_cfg;
		end
	end

	// upper bytes only wait here until the lowest byte arrives
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			entry_hi <= {3{`BYTE_RESET}};
		end else if (fire_wr && hit_d1) begin
			entry_hi[7:0] <= writedata[7:0];
		end else if (fire_wr && hit_d2) begin
			entry_hi[15:8] <= writedata[7:0];
		end else if (fire_wr && hit_d3) begin
			entry_hi[23:16] <= writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// byte sequencer

	width_mirror mirror_u (
		.word     (entry_word),
		.width    (cfg.input_width_sel),
		.reverse  (cfg.reverse),
		.mirrored (mirrored)
	);

	// one byte per cycle, highest byte of the word first
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phase      <= PH_IDLE;
			steps_left <= 2'b00;
			first_step <= 1'b0;
			work       <= 32'h0000_0000;
		end else begin
			unique case (phase)
				PH_IDLE: begin
					if (start) begin
						phase      <= PH_RUN;
						steps_left <= cfg.input_width_sel;
						first_step <= 1'b1;
						work       <= mirrored;
					end
				end
				PH_RUN: begin
					first_step <= 1'b0;
					if (steps_left == 2'b00) begin
						phase <= PH_IDLE;
					end else begin
						steps_left <= steps_left - 2'b01;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// accumulator

	crc_byte_step step_u (
		.alg        (cfg.algorithm_select),
		.keep_carry (~cfg.carry_discard),
		.first      (first_step),
		.cur        (eng),
		.data_byte  (cur_byte),
		.byte_pos   (steps_left),
		.nxt        (next_eng)
	);

	// writes are held off while busy, so these never collide
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			eng <= '0;
		end else if (clear_cmd) begin
			eng.acc   <= seed_default(cfg.algorithm_select);
			eng.carry <= 1'b0;
		end else if (seed_load) begin
			eng.acc <= seed_word;
		end else if (busy) begin
			eng <= next_eng;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking chk_clk @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	width8_cycles_a: assert property (
		start && cfg.input_width_sel == W8 |=> busy ##1 !busy)
		else $error("8-bit entry not done in one cycle");

	width16_cycles_a: assert property (
		start && cfg.input_width_sel == W16 |=> busy[*2] ##1 !busy)
		else $error("16-bit entry not done in two cycles");

	width32_cycles_a: assert property (
		start && cfg.input_width_sel == W32 |=> busy[*4] ##1 !busy)
		else $error("32-bit entry not done in four cycles");

	config_read_a: assert property (
		read && waitrequest && take && hit_cfg |=>
			readdata[0] == $past(busy) &&
			readdata[7:3] == $past(cfg[7:3]) && readdata[2:1] == 2'b00)
		else $error("config read does not show fields and busy");

	reverse_order_a: assert property (
		start && cfg.reverse && cfg.input_width_sel == W8 |=>
			work[0] == $past(writedata[7]) && work[7] == $past(writedata[0]))
		else $error("reversed byte not mirrored");

	result_read_a: assert property (
		read && waitrequest && take && hit_d1 |=>
			readdata[7:0] == $past(eng.acc[15:8]))
		else $error("data port read is not the result");

	seed_normal_a: assert property (
		seed_load |=> eng.acc == $past(seed_word) && !busy)
		else $error("seed not stored in normal order");

	carry_keep_a: assert property (
		busy && cfg.algorithm_select == ALG_CKS8 && !cfg.carry_discard
		|=> eng.acc[7:0] == 8'($past(eng.acc[7:0]) + $past(cur_byte) +
			{7'h00, $past(eng.carry)}))
		else $error("8-bit checksum lost the previous carry");

	carry_drop_a: assert property (
		busy && cfg.algorithm_select == ALG_CKS8 && cfg.carry_discard
		|=> eng.acc[7:0] == 8'($past(eng.acc[7:0]) + $past(cur_byte)))
		else $error("8-bit checksum kept a discarded carry");

	seed_no_calc_a: assert property (
		fire_wr && hit_d0 && cfg.seed |=> !busy)
		else $error("seed write started a calculation");

	clear_seed_a: assert property (
		clear_cmd |=> eng.acc == seed_default($past(cfg.algorithm_select))
			&& !eng.carry &&
			cfg.algorithm_select == $past(cfg.algorithm_select))
		else $error("reset command did not restore the seed");

	busy_bound_a: assert property (
		busy |-> ##[1:4] !busy)
		else $error("busy held longer than four cycles");

	start_calc_a: assert property (
		fire_wr && hit_d0 && !cfg.seed && is_active(cfg.algorithm_select)
		|=> busy && first_step)
		else $error("lowest byte write did not start");

	idle_off_a: assert property (
		fire_wr && hit_d0 && !is_active(cfg.algorithm_select) |=> !busy)
		else $error("disabled accelerator calculated");

	width24_cycles_a: assert property (
		start && cfg.input_width_sel == W24 |=> busy[*3] ##1 !busy)
		else $error("24-bit entry not done in three cycles");

	// seeds checked against the constants, not the seed function
	cks_seed_a: assert property (
		clear_cmd && cfg.algorithm_select inside {ALG_CKS8, ALG_CKS32}
		|=> eng.acc == `SEED_CKS)
		else $error("checksum default seed is not zero");

	crc16_seed_a: assert property (
		clear_cmd && cfg.algorithm_select inside {ALG_CRC16A, ALG_CRC16B}
		|=> eng.acc == `SEED_CRC16)
		else $error("crc16 default seed is not all ones");

	crc32_seed_a: assert property (
		clear_cmd && cfg.algorithm_select == ALG_CRC32
		|=> eng.acc == `SEED_CRC32)
		else $error("crc32 default seed is not all ones");

	seed_carry_a: assert property (
		seed_load |=> eng.carry == $past(eng.carry))
		else $error("seed load disturbed the carry");

	cfg_write_a: assert property (
		cfg_wr && !clear_cmd |=> cfg == $past(wr_cfg))
		else $error("config write did not land");

	mirror_off_a: assert property (
		start && !cfg.reverse && cfg.input_width_sel == W32 |=>
			work == $past(entry_word))
		else $error("word changed although reverse is clear");

	mirror_full_a: assert property (
		start && cfg.reverse && cfg.input_width_sel == W32 |=>
			work[0] == $past(entry_word[31]) &&
			work[31] == $past(entry_word[0]))
		else $error("32-bit word not mirrored");

	// a stalled access must never be answered mid-calculation
	stall_access_a: assert property (
		busy && !(read && hit_cfg) |=> waitrequest)
		else $error("access answered while busy");

	read_upper_a: assert property (
		!waitrequest |-> readdata[31:8] == 24'h00_0000)
		else $error("upper read data lanes not zero");

	bus_pulse_a: assert property (
		!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");

endmodule

// >>> rtl/crc_byte_step.sv
/*
 * One byte of checksum or CRC work, combinational.
 * Assumes the caller registers the result and feeds bytes high first.
 */
`timescale 1ns/1ps
`include "accel_cfg.svh"

module crc_byte_step
	import accel_pkg::*;
(
	// operation
	input  alg_e             alg,
	input  wire logic        keep_carry,
	input  wire logic        first,
	// operand
	input  engine_s          cur,
	input  wire logic [7:0]  data_byte,
	input  wire logic [1:0]  byte_pos,
	// result
	output engine_s          nxt
);

	logic [8:0]  sum8;
	logic [32:0] sum32;
	logic [31:0] addend;
	logic        cin;

	// msb-first shift register, one input bit per step
	function automatic logic [31:0] crc_byte(input logic [31:0] c,
			input logic [7:0] b, input logic [31:0] poly,
			input logic wide);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = (wide ? r[31] : r[15]) ^ b[i];
			r = (r << 1) ^ (fb ? poly : 32'h0000_0000);
		end
		return wide ? r : (r & `MASK_16);
	endfunction

	// 32-bit sum takes the old carry only once per word
	assign cin    = keep_carry & cur.carry & (first | (alg == ALG_CKS8));
	assign addend = {24'h00_0000, data_byte} << {byte_pos, 3'b000};
	assign sum8   = {1'b0, cur.acc[7:0]} + {1'b0, data_byte} +
		{8'h00, cin};
	assign sum32  = {1'b0, cur.acc} + {1'b0, addend} + {32'h0, cin};

	always_comb begin
		nxt = cur;
		unique case (alg)
			ALG_CKS8: begin
				nxt.acc   = {24'h00_0000, sum8[7:0]};
				nxt.carry = sum8[8];
			end
			ALG_CKS32: begin
				nxt.acc   = sum32[31:0];
				nxt.carry = (cur.carry & ~first) | sum32[32];
			end
			ALG_CRC16A: nxt.acc = crc_byte(cur.acc, data_byte, `POLY16_A, 1'b0);
			ALG_CRC16B: nxt.acc = crc_byte(cur.acc, data_byte, `POLY16_B, 1'b0);
			ALG_CRC32:  nxt.acc = crc_byte(cur.acc, data_byte, `POLY32, 1'b1);
			ALG_OFF, ALG_RSVD, ALG_CLEAR: nxt = cur;
		endcase
	end

endmodule

// >>> rtl/width_mirror.sv
/*
 * Bit-order mirror of an entered word across the selected input width.
 * Assumes a purely combinational use from the same clock domain.
 */
`timescale 1ns/1ps
`include "accel_cfg.svh"

module width_mirror
	import accel_pkg::*;
(
	// entered word and options
	input  wire logic [31:0] word,
	input  width_e           width,
	input  wire logic        reverse,
	// word as the algorithm sees it
	output logic      [31:0] mirrored
);

	logic [31:0] full_rev;

	// full reversal then a right shift lands word[n-1-i] on bit i
	assign full_rev = {<<{word}};
	always_comb begin
		if (reverse) begin
			mirrored = full_rev >> {~width, 3'b000};
		end else begin
			mirrored = word & width_mask(width);
		end
	end

endmodule

// >>> tb/cpu_bus_model.sv
/*
 * Bus master standing in for the processor core: byte register
 * reads and writes over Avalon-MM with waitrequest.
 * Assumes the slave lowers waitrequest to answer; a hang is cut by
 * the bench's own timeout.
 */
`timescale 1ns/1ps
`include "accel_cfg.svh"

module cpu_bus_model (
	// clock
	input  wire logic                  sys_clk,
	// avalon-mm master
	output logic      [`AV_ADDR_W-1:0] address,
	output logic                       read,
	output logic                       write,
	output logic      [`AV_DATA_W-1:0] writedata,
	output logic      [3:0]            byteenable,
	input  wire logic [`AV_DATA_W-1:0] readdata,
	input  wire logic                  waitrequest
);

////////////////////////////////////////////////////////////////////////

	initial begin
		address    = '0;
		read       = 1'b0;
		write      = 1'b0;
		writedata  = '0;
		byteenable = 4'h1;
	end

	// released address and data go to the inverse, so a stale value never looks valid
	task automatic access(input logic [15:0] idx, input logic wr,
		input logic [7:0] wd, output logic [31:0] rd, output int waits);
		waits = 0;
		@(posedge sys_clk);
		address   <= {idx, 2'b00};
		writedata <= {24'h0, wd};
		read      <= !wr;
		write     <= wr;
		do begin
			@(posedge sys_clk);
			waits++;
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read      <= 1'b0;
		write     <= 1'b0;
		address   <= ~{idx, 2'b00};
		writedata <= ~{24'h0, wd};
	endtask
endmodule

// >>> tb/tb.sv
/*
 * Self-checking bench of the checksum / CRC accelerator: table of
 * entries, then stall timing, busy, unmapped access and a second reset while idle.
 * Assumes the bus model in cpu_bus_model.sv and the design package.
 */
`timescale 1ns/1ps
`include "accel_cfg.svh"

module tb
	import accel_pkg::*;
();

	typedef struct {
		logic [7:0]  cfg;
		logic        clr;
		logic [31:0] data;
	} row_s;

	logic        sys_clk;
	logic        reset;
	logic [17:0] address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [3:0]  byteenable;
	logic        waitrequest;
	logic [31:0] acc;
	logic        carry;
	int          num_errors;
	int          cmp_count;
	int          cycles;
	row_s        rows [18] = '{
		'{8'h01, 1'b1, 32'h5a}, '{8'h01, 1'b0, 32'ha7},
		'{8'h01, 1'b0, 32'h00}, '{8'h19, 1'b1, 32'hff},
		'{8'h11, 1'b0, 32'h02}, '{8'h11, 1'b0, 32'h00},
		'{8'hc2, 1'b1, 32'h80000001}, '{8'hc2, 1'b0, 32'h80000000},
		'{8'hc2, 1'b0, 32'h0}, '{8'h43, 1'b1, 32'h1234},
		'{8'ha4, 1'b1, 32'h55abcdef}, '{8'he5, 1'b1, 32'hdeadbeef},
		'{8'h05, 1'b0, 32'h31}, '{8'hed, 1'b0, 32'h12345678},
		'{8'he5, 1'b0, 32'h01020304}, '{8'h00, 1'b0, 32'h77},
		'{8'h06, 1'b1, 32'h77}, '{8'h21, 1'b1, 32'h01}};

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	checksum_crc_accelerator u_dut (.sys_clk(sys_clk), .reset(reset),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest));

	cpu_bus_model u_cpu (.sys_clk(sys_clk), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));

////////////////////////////////////////////////////////////////////////

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s: got %h want %h", $time, what, got,
				exp);
		end
	endtask

	task automatic check_count(input int got, input int exp,
		input string what);
		cmp_count++;
		if (got != exp) begin
			num_errors++;
			$display("MISMATCH %0t %s: got %0d want %0d", $time, what,
				got, exp);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s finished", name);
	endtask

	// hang guard, far above the well under a thousand cycles the run needs
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

////////////////////////////////////////////////////////////////////////

	function automatic logic [31:0] amask(input alg_e a);
		if (a == ALG_CKS8)
			return 32'hff;
		if (a == ALG_CRC16A || a == ALG_CRC16B)
			return 32'hffff;
		return 32'hffffffff;
	endfunction

	function automatic logic [31:0] dseed(input alg_e a);
		if (a == ALG_CRC16A || a == ALG_CRC16B)
			return 32'hffff;
		return (a == ALG_CRC32) ? 32'hffffffff : 32'h0;
	endfunction

	// reference: crc msb first, high byte first, no final xor
	task automatic ref_step(input cfg_s c, input logic [31:0] d,
		input int n);
		logic [31:0] m;
		logic [32:0] s;
		logic [31:0] poly;
		int          top;
		m = '0;
		for (int i = 0; i < n; i++)
			m[i] = c.reverse ? d[n-1-i] : d[i];
		poly = (c.algorithm_select == ALG_CRC32) ? 32'h04c11db7 :
			(c.algorithm_select == ALG_CRC16A) ? 32'h8005 : 32'h1021;
		top = (c.algorithm_select == ALG_CRC32) ? 31 : 15;
		case (c.algorithm_select)
			ALG_CKS8: begin
				for (int k = n / 8 - 1; k >= 0; k--) begin
					s = acc[7:0] + m[8*k+:8] + (carry & ~c.carry_discard);
					acc = {24'h0, s[7:0]};
					carry = s[8];
				end
			end
			ALG_CKS32: begin
				s = acc + m + (carry & ~c.carry_discard);
				acc = s[31:0];
				carry = s[32];
			end
			ALG_CRC16A, ALG_CRC16B, ALG_CRC32: begin
				for (int b = n - 1; b >= 0; b--)
					acc = ({acc[30:0], 1'b0} ^ ((acc[top] ^ m[b]) ? poly :
						32'h0)) & amask(c.algorithm_select);
			end
			default: ;
		endcase
	endtask

	task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		int          w;
		u_cpu.access(idx, 1'b1, d, r, w);
	endtask

	task automatic rd_reg(input logic [15:0] idx, output logic [31:0] r);
		int w;
		u_cpu.access(idx, 1'b0, 8'h00, r, w);
	endtask

	task automatic get_word(output logic [31:0] r);
		logic [31:0] b;
		for (int k = 0; k < 4; k++) begin
			rd_reg(`IDX_DATA0 + 16'(k), b);
			r[8*k+:8] = b[7:0];
		end
	endtask

	task automatic entry(input cfg_s c, input logic [31:0] d);
		int          n;
		logic [31:0] wm;
		n = 8 * (int'(c.input_width_sel) + 1);
		for (int k = n / 8 - 1; k > 0; k--)
			wr_reg(`IDX_DATA0 + 16'(k), d[8*k+:8]);
		wr_reg(`IDX_DATA0, d[7:0]);
		wm = (n == 32) ? 32'hffffffff : (32'h1 << n) - 32'h1;
		if (c.seed)
			acc = d & wm & amask(c.algorithm_select);
		else
			ref_step(c, d, n);
	endtask

////////////////////////////////////////////////////////////////////////

	initial begin
		logic [31:0] got;
		cfg_s        c;
		int          waits [4];
		reset = 1'b1;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		acc = '0;
		carry = 1'b0;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd_reg(`IDX_CONFIG, got);
		check(got, 32'h0, "config after reset");
		get_word(got);
		check(got, 32'h0, "data after reset");
		end_test("reset values");

		for (int r = 0; r < 18; r++) begin
			c = cfg_s'(rows[r].cfg);
			wr_reg(`IDX_CONFIG, rows[r].cfg);
			if (rows[r].clr) begin
				wr_reg(`IDX_CONFIG, rows[r].cfg | 8'h07);
				acc = dseed(c.algorithm_select);
				carry = 1'b0;
				get_word(got);
				check(got, acc, "default seed");
			end
			entry(c, rows[r].data);
			get_word(got);
			check(got, acc, "result");
			rd_reg(`IDX_CONFIG, got);
			check(got, {24'h0, rows[r].cfg & 8'hf8}, "config");
		end
		end_test("entry table");

		// a data read right after an entry is stalled until done
		for (int w = 1; w < 4; w++) begin
			c = cfg_s'({2'(w), 6'h05});
			wr_reg(`IDX_CONFIG, c);
			entry(c, 32'h0102_0304);
			u_cpu.access(`IDX_DATA0, 1'b0, 8'h00, got, waits[w]);
			check(got, {24'h0, acc[7:0]}, "stalled read");
		end
		check_count(waits[2] - waits[1], 1, "24 vs 16 bit");
		check_count(waits[3] - waits[1], 2, "32 vs 16 bit");
		end_test("entry length");

		entry(c, 32'hcafe_f00d);
		rd_reg(`IDX_CONFIG, got);
		check(got & 32'h1, 32'h1, "busy just after entry");
		get_word(got);
		check(got, acc, "result after busy");
		end_test("busy");

		wr_reg(16'h0001, 8'h3c);
		rd_reg(16'h0001, got);
		check(got, 32'h0, "unmapped read");
		get_word(got);
		check(got, acc, "after unmapped write");
		end_test("unmapped");

		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd_reg(`IDX_CONFIG, got);
		check(got, 32'h0, "config after second reset");
		get_word(got);
		check(got, 32'h0, "data after second reset");
		end_test("second reset");
		test_done();
	end
endmodule
